// ### crt_timing_register_set.sv
// Display timing register set with counters, sync/blank generation and host port
`timescale 1ns/1ps
`default_nettype none
module crt_timing_register_set
  #(parameter int SKEW_DEPTH = 3)
  (
  input  wire logic                          clk,
  input  wire logic                          sys_rst,
  input  wire crt_timing_pkg::host_req_t     host_req,
  output var  logic [7:0]                    host_rdata,
  input  wire logic [7:0]                    horizontal_total,
  input  wire logic [7:0]                    hdisplay_end,
  input  wire logic                          ext_group0_protect,
  input  wire logic                          byte_word_select,
  input  wire logic                          count_by_two_select,
  input  wire logic                          aux_pitch_half,
  input  wire logic                          mono_emulation,
  input  wire crt_timing_pkg::wrap_mode_t    wrap_mode,
  input  wire logic                          pen_strobe,
  output var  crt_timing_pkg::crt_signals_t  crt,
  output var  logic [15:0]                   mem_addr,
  output var  logic [4:0]                    row_scan,
  output var  logic                          vert_irq,
  output var  logic [2:0]                    refresh_per_line
  );
  import crt_timing_pkg::*;

  // ============================================================
  // Register storage
  logic [5:0]  index;
  logic [7:0]  regs [IDX_HBLANK_START:IDX_UNDERLINE];
  logic [7:0]  pen_high;
  logic [7:0]  pen_low;

  logic        protect0;
  logic        data_wr;
  logic        data_rd;
  logic        pen_view;
  assign protect0 = regs[IDX_VSYNC_LOW_PEN][VSE_PROTECT_BIT] | ext_group0_protect;
  assign data_wr  = host_req.wr & host_req.data_sel;
  assign data_rd  = host_req.rd & host_req.data_sel;
  assign pen_view = mono_emulation | ~regs[IDX_HBLANK_END][PEN_SELECT_BIT];

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      index <= 6'h00;
    else if (host_req.wr && !host_req.data_sel)
      index <= host_req.wdata[5:0];
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      for (int i = IDX_HBLANK_START; i <= IDX_UNDERLINE; i++)
        regs[i] <= REG_RESET;
    end
    else if (data_wr && index >= IDX_HBLANK_START && index <= IDX_UNDERLINE)
    begin
      if (index == IDX_OVERFLOW && protect0)
        regs[index][OVF_LINE_COMPARE_BIT] <= host_req.wdata[OVF_LINE_COMPARE_BIT];
      else if (!(protect0 && index <= IDX_GROUP0_LAST))
        regs[index] <= host_req.wdata;
    end
  end

  // Pen registers are read-only, so writes at 0x10/0x11 always land in vsync storage
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      host_rdata <= 8'h00;
    else if (host_req.rd && !host_req.data_sel)
      host_rdata <= {2'b00, index};
    else if (data_rd)
    begin
      if (index == IDX_VSYNC_HIGH_PEN && pen_view)
        host_rdata <= pen_high;
      else if (index == IDX_VSYNC_LOW_PEN && pen_view)
        host_rdata <= pen_low;
      else if (index >= IDX_HBLANK_START && index <= IDX_UNDERLINE)
        host_rdata <= regs[index];
      else
        host_rdata <= 8'h00;
    end
  end

  // ============================================================
  // Decoded fields
  logic [7:0] hblank_start;
  logic [5:0] hblank_end6;
  logic [7:0] hsync_start;
  logic [4:0] hsync_end5;
  logic [1:0] de_skew;
  logic [1:0] hs_skew;
  logic [1:0] cur_skew;
  logic [9:0] vtotal;
  logic [9:0] vdisp_end;
  logic [9:0] vsync_start;
  logic [3:0] vsync_end4;
  logic [4:0] max_scan;
  logic       double_scan;
  logic [4:0] cursor_top;
  logic [4:0] cursor_bottom;
  logic       cursor_off;
  logic [15:0] start_addr;
  logic [15:0] cursor_addr;
  logic [4:0] underline_row;
  logic       dword_mode;

  assign hblank_start  = regs[IDX_HBLANK_START];
  assign hblank_end6   = {regs[IDX_HSYNC_END][HSE_BLANK_BIT5],
                          regs[IDX_HBLANK_END][4:0]};
  assign hsync_start   = regs[IDX_HSYNC_START];
  assign hsync_end5    = regs[IDX_HSYNC_END][4:0];
  assign de_skew       = regs[IDX_HBLANK_END][6:5];
  assign hs_skew       = regs[IDX_HSYNC_END][6:5];
  assign cur_skew      = regs[IDX_CURSOR_BOTTOM][6:5];
  assign vtotal        = {regs[IDX_OVERFLOW][5], regs[IDX_OVERFLOW][0],
                          regs[IDX_VTOTAL_LOW]};
  assign vdisp_end     = {regs[IDX_OVERFLOW][6], regs[IDX_OVERFLOW][1],
                          regs[IDX_VDISP_END_LOW]};
  assign vsync_start   = {regs[IDX_OVERFLOW][7], regs[IDX_OVERFLOW][2],
                          regs[IDX_VSYNC_HIGH_PEN]};
  assign vsync_end4    = regs[IDX_VSYNC_LOW_PEN][3:0];
  assign max_scan      = regs[IDX_MAX_SCAN][4:0];
  assign double_scan   = regs[IDX_MAX_SCAN][MSL_DOUBLE_BIT];
  assign cursor_top    = regs[IDX_CURSOR_TOP][4:0];
  assign cursor_bottom = regs[IDX_CURSOR_BOTTOM][4:0];
  assign cursor_off    = regs[IDX_CURSOR_TOP][CUR_OFF_BIT];
  assign start_addr    = {regs[IDX_START_HIGH], regs[IDX_START_LOW][7:2],
                          regs[IDX_PRESET_ROW][6:5]};
  assign cursor_addr   = {regs[IDX_CURSOR_HIGH], regs[IDX_CURSOR_LOW]};
  assign underline_row = regs[IDX_UNDERLINE][4:0];
  assign dword_mode    = regs[IDX_UNDERLINE][UL_DWORD_BIT];

  function automatic logic [15:0] wrap_addr(input logic [15:0] a, input wrap_mode_t m);
    unique case (m)
      WRAP_16K: wrap_addr = a & WRAP_MASK_16K;
      WRAP_32K: wrap_addr = a & WRAP_MASK_32K;
      WRAP_64K: wrap_addr = a & WRAP_MASK_64K;
      WRAP_NONE: wrap_addr = a;
    endcase
  endfunction

  function automatic logic skew_tap(input logic raw, input logic [SKEW_DEPTH-1:0] pipe,
                                    input logic [1:0] sel);
    skew_tap = (sel == 2'd0) ? raw : pipe[sel - 2'd1];
  endfunction

  // ============================================================
  // Horizontal and vertical counters
  logic [8:0] hcount;
  logic [9:0] vcount;
  logic       line_end;
  logic       frame_end;
  assign line_end  = (hcount == {1'b0, horizontal_total} + HTOTAL_EXTRA);
  assign frame_end = line_end && (vcount == vtotal + VTOTAL_EXTRA);

  always_ff @(posedge clk)
  begin
    if (sys_rst || line_end)
      hcount <= 9'h000;
    else
      hcount <= hcount + 9'h001;
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst || frame_end)
      vcount <= 10'h000;
    else if (line_end)
      vcount <= vcount + 10'h001;
  end

  // ============================================================
  // Horizontal blank and sync, equality compares only
  logic hblank_raw;
  logic hsync_raw;
  logic vsync_raw;
  logic vdisp;

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      hblank_raw <= 1'b0;
    else if (hcount == {1'b0, hblank_start})
      hblank_raw <= 1'b1;
    else if (hcount[5:0] == hblank_end6)
      hblank_raw <= 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      hsync_raw <= 1'b0;
    else if (hcount == {1'b0, hsync_start})
      hsync_raw <= 1'b1;
    else if (hcount[4:0] == hsync_end5)
      hsync_raw <= 1'b0;
  end

  // Vertical compares are taken at line boundaries so each edge happens once a frame
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      vsync_raw <= 1'b0;
    else if (line_end && vcount == vsync_start)
      vsync_raw <= 1'b1;
    else if (line_end && vcount[3:0] == vsync_end4)
      vsync_raw <= 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst || frame_end)
      vdisp <= 1'b1;
    else if (line_end && vcount == vdisp_end)
      vdisp <= 1'b0;
  end

  // ============================================================
  // Vertical interrupt, set wins over a clear in the same cycle
  logic irq_event;
  assign irq_event = line_end && vcount == vsync_start
                     && !regs[IDX_VSYNC_LOW_PEN][VSE_IRQ_DISABLE_BIT];

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      vert_irq <= 1'b0;
    else
      vert_irq <= irq_event | (vert_irq & regs[IDX_VSYNC_LOW_PEN][VSE_IRQ_CLEAR_BIT]);
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      refresh_per_line <= REFRESH_SHORT;
    else
      refresh_per_line <= regs[IDX_VSYNC_LOW_PEN][VSE_REFRESH_BIT] ? REFRESH_LONG
                                                                   : REFRESH_SHORT;
  end

  // ============================================================
  // Row scan and memory addressing
  logic        scan_half;
  logic [15:0] row_start;
  logic [15:0] char_addr;
  logic [15:0] char_step;
  logic [15:0] pitch_step;
  logic        row_done;

  // Step per character clock: 1, 2 or 4 bytes
  assign char_step = regs[IDX_UNDERLINE][UL_COUNT4_BIT]
                   ? (count_by_two_select ? 16'h0002 : 16'h0004)
                   : (count_by_two_select ? 16'h0002 : 16'h0001);
  // K times (pitch + Z/2) kept in half units; doubleword takes K = 4
  assign pitch_step = {7'h00, regs[IDX_ROW_PITCH], aux_pitch_half}
                      << (dword_mode ? 2 : (byte_word_select ? 0 : 1));
  assign row_done   = (row_scan == max_scan) && (!double_scan || scan_half);

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      row_scan  <= 5'h00;
      scan_half <= 1'b0;
    end
    else if (frame_end)
    begin
      row_scan  <= regs[IDX_PRESET_ROW][4:0];
      scan_half <= 1'b0;
    end
    else if (line_end && vdisp)
    begin
      scan_half <= double_scan ? ~scan_half : 1'b0;
      if (double_scan && !scan_half)
        row_scan <= row_scan;
      else if (row_done)
        row_scan <= 5'h00;
      else
        row_scan <= row_scan + 5'h01;
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst || frame_end)
      row_start <= start_addr;
    else if (line_end && vdisp && row_done)
      row_start <= wrap_addr(row_start + pitch_step, wrap_mode);
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst || line_end)
      char_addr <= wrap_addr(row_start, wrap_mode);
    else if (hcount <= {1'b0, hdisplay_end})
      char_addr <= wrap_addr(char_addr + char_step, wrap_mode);
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      mem_addr <= 16'h0000;
    else
      mem_addr <= char_addr;
  end

  // ============================================================
  // Cursor and underline
  logic cursor_raw;
  assign cursor_raw = !cursor_off && cursor_top <= cursor_bottom
                      && row_scan >= cursor_top && row_scan <= cursor_bottom
                      && char_addr == wrap_addr(cursor_addr, wrap_mode);

  // ============================================================
  // Skew pipelines for enable, sync and cursor
  logic                  de_raw;
  logic [SKEW_DEPTH-1:0] de_pipe;
  logic [SKEW_DEPTH-1:0] hs_pipe;
  logic [SKEW_DEPTH-1:0] cur_pipe;
  assign de_raw = vdisp && hcount <= {1'b0, hdisplay_end};

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      de_pipe  <= '0;
      hs_pipe  <= '0;
      cur_pipe <= '0;
    end
    else
    begin
      de_pipe  <= {de_pipe[SKEW_DEPTH-2:0], de_raw};
      hs_pipe  <= {hs_pipe[SKEW_DEPTH-2:0], hsync_raw};
      cur_pipe <= {cur_pipe[SKEW_DEPTH-2:0], cursor_raw};
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      crt <= '0;
    else
    begin
      crt.hsync          <= skew_tap(hsync_raw, hs_pipe, hs_skew);
      crt.display_enable <= skew_tap(de_raw, de_pipe, de_skew);
      crt.cursor         <= skew_tap(cursor_raw, cur_pipe, cur_skew);
      crt.hblank         <= hblank_raw;
      crt.vsync          <= vsync_raw;
      crt.underline      <= de_raw && (row_scan == underline_row + 5'h01);
    end
  end

  // ============================================================
  // Light pen capture; pin passes three flops before use
  logic pen_meta;
  logic pen_s2;
  logic pen_s3;
  logic pen_level;

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      pen_meta  <= 1'b0;
      pen_s2    <= 1'b0;
      pen_s3    <= 1'b0;
      pen_level <= 1'b0;
    end
    else
    begin
      pen_meta <= pen_strobe;
      pen_s2   <= pen_meta;
      pen_s3   <= pen_s2;
      if (pen_s2 == pen_s3)
        pen_level <= pen_s3;
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      pen_high <= 8'h00;
      pen_low  <= 8'h00;
    end
    else if (pen_s2 == pen_s3 && pen_s3 && !pen_level)
    begin
      pen_high <= char_addr[15:8];
      pen_low  <= char_addr[7:0];
    end
  end

  // ============================================================
  // Checks
  property p_hblank_on;
    @(posedge clk) disable iff (sys_rst)
      (hcount == {1'b0, hblank_start}) |=> hblank_raw;
  endproperty
  a_hblank_on: assert property (p_hblank_on) else $error("hblank not started");

  property p_hblank_off;
    @(posedge clk) disable iff (sys_rst)
      (hcount != {1'b0, hblank_start} && hcount[5:0] == hblank_end6) |=> !hblank_raw;
  endproperty
  a_hblank_off: assert property (p_hblank_off) else $error("hblank not ended");

  property p_hsync_span;
    @(posedge clk) disable iff (sys_rst)
      (hcount == {1'b0, hsync_start} && hsync_end5 == hsync_start[4:0] + 5'h03)
      |=> hsync_raw [*3] ##1 !hsync_raw;
  endproperty
  a_hsync_span: assert property (p_hsync_span) else $error("hsync width wrong");

  property p_skew_zero;
    @(posedge clk) disable iff (sys_rst)
      (hs_skew == 2'd0) |=> crt.hsync == $past(hsync_raw);
  endproperty
  a_skew_zero: assert property (p_skew_zero) else $error("hsync delay wrong");

  property p_frame_wrap;
    @(posedge clk) disable iff (sys_rst)
      frame_end |=> (vcount == 10'h000 && hcount == 9'h000);
  endproperty
  a_frame_wrap: assert property (p_frame_wrap) else $error("frame did not wrap");

  property p_protect;
    @(posedge clk) disable iff (sys_rst)
      (data_wr && protect0 && index == IDX_HSYNC_START)
      |=> regs[IDX_HSYNC_START] == $past(regs[IDX_HSYNC_START]);
  endproperty
  a_protect: assert property (p_protect) else $error("protected write landed");

  property p_irq_clear;
    @(posedge clk) disable iff (sys_rst)
      (!regs[IDX_VSYNC_LOW_PEN][VSE_IRQ_CLEAR_BIT] && !irq_event) |=> !vert_irq;
  endproperty
  a_irq_clear: assert property (p_irq_clear) else $error("interrupt not cleared");

  property p_index_read;
    @(posedge clk) disable iff (sys_rst)
      (host_req.rd && !host_req.data_sel) |=> host_rdata == {2'b00, $past(index)};
  endproperty
  a_index_read: assert property (p_index_read) else $error("index readback wrong");

  property p_pen_read;
    @(posedge clk) disable iff (sys_rst)
      (data_rd && index == IDX_VSYNC_HIGH_PEN && pen_view) |=> host_rdata == $past(pen_high);
  endproperty
  a_pen_read: assert property (p_pen_read) else $error("pen readback wrong");

  property p_row_load;
    @(posedge clk) disable iff (sys_rst)
      frame_end |=> row_scan == $past(regs[IDX_PRESET_ROW][4:0]);
  endproperty
  a_row_load: assert property (p_row_load) else $error("row scan not preset");

  c_hsync:  cover property (@(posedge clk) disable iff (sys_rst) $rose(crt.hsync));
  c_irq:    cover property (@(posedge clk) disable iff (sys_rst) $rose(vert_irq));
  c_cursor: cover property (@(posedge clk) disable iff (sys_rst) crt.cursor);
  c_vsync:  cover property (@(posedge clk) disable iff (sys_rst) $fell(crt.vsync));

endmodule
`default_nettype wire

// ### crt_timing_pkg.sv
// Constants, register fields and carrier types for the display timing register set
// ============================================================
// Overview of operation
// - Horizontal blank starts at 8-bit start count
// - Horizontal blank ends on 6-bit count match
// - Enable, sync, cursor each delayed 0-3 clocks
// - Readback select picks pen or vsync registers
// - Hsync starts at count, ends 5-bit match
// - Vertical total holds line count minus two
// - Overflow register carries vertical high bits
// - Row scan loads preset, counts, clears at max
// - Byte panning gives lowest start address bits
// - Max scan line is row lines minus one
// - Double scan repeats lines, vertical timing unchanged
// - Cursor spans start to end, off bit
// - Start address 16 bits, legacy wrap boundaries
// - Cursor shown at 16-bit cursor address
// - Pen registers read-only, mono or select clear
// - Vsync starts 10-bit match, ends 4-bit match
// - Interrupt clear bit and disable bit, reset zero
// - Refresh select gives three or five cycles
// - Protect bit blocks writes to indices 0-7, except the overflow line compare bit
// - Display end is last displayed line
// - Row start advances by K times pitch step
// - Underline row, count-by-four, doubleword select
// - Index register six bits, top bits zero
// - Line length is total plus five clocks
package crt_timing_pkg;

  // ============================================================
  // Register indices
  localparam logic [5:0] IDX_HBLANK_START   = 6'h02;
  localparam logic [5:0] IDX_HBLANK_END     = 6'h03;
  localparam logic [5:0] IDX_HSYNC_START    = 6'h04;
  localparam logic [5:0] IDX_HSYNC_END      = 6'h05;
  localparam logic [5:0] IDX_VTOTAL_LOW     = 6'h06;
  localparam logic [5:0] IDX_OVERFLOW       = 6'h07;
  localparam logic [5:0] IDX_PRESET_ROW     = 6'h08;
  localparam logic [5:0] IDX_MAX_SCAN       = 6'h09;
  localparam logic [5:0] IDX_CURSOR_TOP     = 6'h0a;
  localparam logic [5:0] IDX_CURSOR_BOTTOM  = 6'h0b;
  localparam logic [5:0] IDX_START_HIGH     = 6'h0c;
  localparam logic [5:0] IDX_START_LOW      = 6'h0d;
  localparam logic [5:0] IDX_CURSOR_HIGH    = 6'h0e;
  localparam logic [5:0] IDX_CURSOR_LOW     = 6'h0f;
  localparam logic [5:0] IDX_VSYNC_HIGH_PEN = 6'h10;
  localparam logic [5:0] IDX_VSYNC_LOW_PEN  = 6'h11;
  localparam logic [5:0] IDX_VDISP_END_LOW  = 6'h12;
  localparam logic [5:0] IDX_ROW_PITCH      = 6'h13;
  localparam logic [5:0] IDX_UNDERLINE      = 6'h14;
  localparam logic [5:0] IDX_GROUP0_LAST    = 6'h07;

  // ============================================================
  // Field positions
  localparam int OVF_LINE_COMPARE_BIT = 4;
  localparam int VSE_IRQ_CLEAR_BIT    = 4;
  localparam int VSE_IRQ_DISABLE_BIT  = 5;
  localparam int VSE_REFRESH_BIT      = 6;
  localparam int VSE_PROTECT_BIT      = 7;
  localparam int CUR_OFF_BIT          = 5;
  localparam int MSL_DOUBLE_BIT       = 7;
  localparam int UL_COUNT4_BIT        = 5;
  localparam int UL_DWORD_BIT         = 6;
  localparam int PEN_SELECT_BIT       = 7;
  localparam int HSE_BLANK_BIT5       = 7;

  // ============================================================
  // Reset values and timing counts
  localparam logic [7:0] REG_RESET         = 8'h00;
  localparam logic [8:0] HTOTAL_EXTRA      = 9'h004;
  localparam logic [9:0] VTOTAL_EXTRA      = 10'h001;
  localparam logic [2:0] REFRESH_SHORT     = 3'h3;
  localparam logic [2:0] REFRESH_LONG      = 3'h5;
  localparam logic [15:0] WRAP_MASK_16K    = 16'h3fff;
  localparam logic [15:0] WRAP_MASK_32K    = 16'h7fff;
  localparam logic [15:0] WRAP_MASK_64K    = 16'hffff;

  typedef enum logic [1:0] {WRAP_NONE, WRAP_16K, WRAP_32K, WRAP_64K} wrap_mode_t;

  // Timing outputs toward the monitor and the pixel path
  typedef struct packed {
    logic hsync;
    logic vsync;
    logic hblank;
    logic display_enable;
    logic cursor;
    logic underline;
  } crt_signals_t;

  // Host port request
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic       data_sel;
    logic [7:0] wdata;
  } host_req_t;

endpackage

// ### crt_monitor_model.sv
// Monitor model measuring line length and pulse widths of the hsync and hblank outputs
`timescale 1ns/1ps
`default_nettype none
module crt_monitor_model
  (
  input  wire logic                          clk,
  input  wire crt_timing_pkg::crt_signals_t  crt,
  output var  logic [15:0]                   line_len,
  output var  logic [15:0]                   hs_width,
  output var  logic [15:0]                   hb_width
  );
  import crt_timing_pkg::*;
  logic [15:0] cnt = '0;
  logic [15:0] hs_cnt = '0;
  logic [15:0] hb_cnt = '0;
  logic        hs_d = 1'b0;
  logic        hb_d = 1'b0;
  // ============================================================
  // Sync period and widths, in character clocks
  always_ff @(posedge clk)
  begin
    hs_d <= crt.hsync;
    hb_d <= crt.hblank;
    cnt <= (crt.hsync && !hs_d) ? 16'h0001 : cnt + 16'h0001;
    if (crt.hsync && !hs_d)
      line_len <= cnt;
    hs_cnt <= crt.hsync ? (hs_d ? hs_cnt + 16'h0001 : 16'h0001) : hs_cnt;
    hb_cnt <= crt.hblank ? (hb_d ? hb_cnt + 16'h0001 : 16'h0001) : hb_cnt;
    if (!crt.hsync && hs_d)
      hs_width <= hs_cnt;
    if (!crt.hblank && hb_d)
      hb_width <= hb_cnt;
  end
endmodule
`default_nettype wire

// ### tb_top.sv
// Testbench for the display timing register set
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin errors++; \
  $display("wrong value %s expected %h seen %h", nm, e, g); end end
module tb_top;
  import crt_timing_pkg::*;
  logic clk, sys_rst, prot, mono;
  host_req_t host_req;
  logic [7:0] rdata, htot;
  crt_signals_t crt;
  logic [15:0] line_len, hs_width, hb_width;
  logic [7:0] d;
  logic [2:0] refresh;
  logic irq;
  int errors = 0;
  int n_tests = 0;
  crt_timing_register_set uut (.clk(clk), .sys_rst(sys_rst), .host_req(host_req),
    .host_rdata(rdata), .horizontal_total(htot), .hdisplay_end(8'h10),
    .ext_group0_protect(prot), .byte_word_select(1'b1), .count_by_two_select(1'b0),
    .aux_pitch_half(1'b0), .mono_emulation(mono), .wrap_mode(WRAP_NONE),
    .pen_strobe(1'b0), .crt(crt), .mem_addr(), .row_scan(), .vert_irq(irq),
    .refresh_per_line(refresh));
  crt_monitor_model mon (.clk(clk), .crt(crt), .line_len(line_len),
    .hs_width(hs_width), .hb_width(hb_width));
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // ============================================================
  // Host port cycles
  task automatic wr(input logic sel, input logic [7:0] v);
    @(posedge clk);
    host_req <= '{1'b1, 1'b0, sel, v};
    @(posedge clk);
    host_req <= '0;
  endtask
  task automatic wreg(input logic [5:0] i, input logic [7:0] v);
    wr(1'b0, {2'b00, i});
    wr(1'b1, v);
  endtask
  task automatic rd(input logic sel, output logic [7:0] v);
    @(posedge clk);
    host_req <= '{1'b0, 1'b1, sel, 8'h00};
    @(posedge clk);
    host_req <= '0;
    @(negedge clk);
    v = rdata;
  endtask
  task automatic rreg(input logic [5:0] i, output logic [7:0] v);
    wr(1'b0, {2'b00, i});
    rd(1'b1, v);
  endtask
  // ============================================================
  // Scenarios
  task automatic t_index();
    wr(1'b0, 8'hc4);
    rd(1'b0, d);
    `CHK("index", 8'h04, d)
    wreg(IDX_ROW_PITCH, 8'h5a);
    rreg(IDX_ROW_PITCH, d);
    `CHK("row_pitch", 8'h5a, d)
    wreg(6'h20, 8'h77);
    rreg(6'h20, d);
    `CHK("unmapped", 8'h00, d)
  endtask
  task automatic t_hsync();
    wreg(IDX_HSYNC_START, 8'h0a);
    wreg(IDX_HSYNC_END, 8'h0d);
    wreg(IDX_HBLANK_START, 8'h05);
    wreg(IDX_HBLANK_END, 8'h89);
    @(posedge clk);
    htot <= 8'd20;
    repeat (100) @(posedge clk);
    `CHK("line_len", 16'd25, line_len)
    `CHK("hs_width", 16'd3, hs_width)
    `CHK("hb_width", 16'd4, hb_width)
  endtask
  task automatic t_pen();
    wreg(IDX_VSYNC_HIGH_PEN, 8'h5a);
    rreg(IDX_VSYNC_HIGH_PEN, d);
    `CHK("vsync_start", 8'h5a, d)
    wreg(IDX_HBLANK_END, 8'h09);
    rreg(IDX_VSYNC_HIGH_PEN, d);
    `CHK("pen_high", 8'h00, d)
    wreg(IDX_HBLANK_END, 8'h89);
    @(posedge clk);
    mono <= 1'b1;
    rreg(IDX_VSYNC_HIGH_PEN, d);
    `CHK("pen_mono", 8'h00, d)
    @(posedge clk);
    mono <= 1'b0;
  endtask
  task automatic t_protect();
    wreg(IDX_VSYNC_LOW_PEN, 8'hb0);
    wreg(IDX_HSYNC_START, 8'h22);
    rreg(IDX_HSYNC_START, d);
    `CHK("protected", 8'h0a, d)
    wreg(IDX_OVERFLOW, 8'hff);
    rreg(IDX_OVERFLOW, d);
    `CHK("overflow", 8'h10, d)
    wreg(IDX_VSYNC_LOW_PEN, 8'h70);
    @(posedge clk);
    @(negedge clk);
    `CHK("refresh", 3'h5, refresh)
    @(posedge clk);
    prot <= 1'b1;
    wreg(IDX_HSYNC_START, 8'h33);
    rreg(IDX_HSYNC_START, d);
    `CHK("ext_protect", 8'h0a, d)
    @(posedge clk);
    prot <= 1'b0;
  endtask
  // Four-line frame, vsync at line 1, interrupt enabled then cleared
  task automatic t_irq();
    wreg(IDX_VTOTAL_LOW, 8'h02);
    wreg(IDX_VSYNC_HIGH_PEN, 8'h01);
    wreg(IDX_VSYNC_LOW_PEN, 8'h13);
    repeat (200) @(posedge clk);
    @(negedge clk);
    `CHK("irq_set", 1'b1, irq)
    wreg(IDX_VSYNC_LOW_PEN, 8'h23);
    @(posedge clk);
    @(negedge clk);
    `CHK("irq_clear", 1'b0, irq)
  endtask
  // ============================================================
  // Verdict, watchdog and main sequence
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial
  begin
    repeat (20000) @(posedge clk);
    errors++;
    print_verdict();
  end
  initial
  begin
    sys_rst = 1'b1;
    host_req = '0;
    htot = 8'h00;
    prot = 1'b0;
    mono = 1'b0;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    @(negedge clk);
    `CHK("refresh_rst", 3'h3, refresh)
    `CHK("irq_rst", 1'b0, irq)
    t_index();
    t_hsync();
    t_pen();
    t_protect();
    t_irq();
    print_verdict();
  end
endmodule
`default_nettype wire
